// [hw/pin_sync.sv]
// Three-stage synchroniser for one asynchronous pin with edge pulse.
// Assumes the pin is unrelated to aclk; the level changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic ff1_q, ff2_q, ff3_q, level_q, rise_q;
	logic level_d, rise_d;

	always_comb begin
		level_d = level_q;
		if (ff2_q == ff3_q) begin
			level_d = ff3_q;
		end
		rise_d = level_d & ~level_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ff1_q <= 1'b0;
			ff2_q <= 1'b0;
			ff3_q <= 1'b0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			ff1_q <= pin;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
			level_q <= level_d;
			rise_q <= rise_d;
		end
	end

	assign level = level_q;
	assign rise = rise_q;
endmodule

// [hw/pll_divider_chain.sv]
// Divider chain of an integer-N synthesizer: serial loader, reference and feedback dividers, phase detector.
// Assumes pins are asynchronous to aclk and toggle well below a quarter of its rate.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module pll_divider_chain
	import pll_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic load_strobe,
	input wire logic ref_in,
	input wire logic rf_in,
	output logic pump_output_up,
	output logic pump_output_down,
	output logic ref_div_out,
	output logic fb_div_out
);

	function automatic logic addr_mapped(input logic [AXI_ADDR_WIDTH-1:0] addr);
		addr_mapped = (addr == OFS_CTRL) || (addr == OFS_STATUS) || (addr == OFS_REF_LATCH) ||
			(addr == OFS_FB_LATCH) || (addr == OFS_FUNC_LATCH) || (addr == OFS_SHIFT);
	endfunction

	// Pin synchronisers
	logic [PIN_COUNT-1:0] pin_raw, pin_level, pin_rise;
	assign pin_raw = {rf_in, ref_in, load_strobe, serial_data, serial_clock};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			pin_sync u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin(pin_raw[gi]),
				.level(pin_level[gi]),
				.rise(pin_rise[gi])
			);
		end
	endgenerate

	// Serial loader and latches
	logic [SHIFT_WIDTH-1:0] shift_q, shift_d;
	ref_latch_type ref_latch_q, ref_latch_d;
	fb_latch_type fb_latch_q, fb_latch_d;
	func_latch_type func_latch_q, func_latch_d;

	always_comb begin
		shift_d = shift_q;
		ref_latch_d = ref_latch_q;
		fb_latch_d = fb_latch_q;
		func_latch_d = func_latch_q;
		if (pin_rise[PIN_SCLK]) begin
			shift_d = {shift_q[SHIFT_WIDTH-2:0], pin_level[PIN_SDATA]};
		end
		if (pin_rise[PIN_LOAD]) begin
			case (shift_q[ADDR_LSB +: 2])
				ADDR_REF: begin
					ref_latch_d.ratio = shift_q[REF_LSB +: REF_WIDTH];
				end
				ADDR_FB: begin
					fb_latch_d.swallow_count = shift_q[SWALLOW_LSB +: SWALLOW_WIDTH];
					fb_latch_d.main_feedback_count = shift_q[MAIN_LSB +: MAIN_WIDTH];
				end
				ADDR_FUNC: begin
					func_latch_d.prescaler_high = shift_q[PRESCALER_SEL_BIT];
					func_latch_d.pump_polarity = shift_q[POLARITY_BIT];
				end
				default: begin
					func_latch_d = func_latch_q;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '0;
			ref_latch_q <= '{ratio: REF_RESET};
			fb_latch_q <= '{main_feedback_count: MAIN_RESET, swallow_count: SWALLOW_RESET};
			func_latch_q <= '{pump_polarity: POLARITY_RESET, prescaler_high: PRESCALER_SEL_RESET};
		end else begin
			shift_q <= shift_d;
			ref_latch_q <= ref_latch_d;
			fb_latch_q <= fb_latch_d;
			func_latch_q <= func_latch_d;
		end
	end

	// Reference divider
	logic [REF_WIDTH-1:0] ref_cnt_q, ref_cnt_d, ref_ratio;
	logic ref_div_q, ref_div_d;

	always_comb begin
		// ratios below two run as two
		ref_ratio = (ref_latch_q.ratio < REF_MIN) ? REF_MIN : ref_latch_q.ratio;
		ref_cnt_d = ref_cnt_q;
		ref_div_d = 1'b0;
		if (pin_rise[PIN_REF]) begin
			if (ref_cnt_q >= ref_ratio - 15'h0001) begin
				ref_cnt_d = '0;
				ref_div_d = 1'b1;
			end else begin
				ref_cnt_d = ref_cnt_q + 15'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_cnt_q <= '0;
			ref_div_q <= 1'b0;
		end else begin
			ref_cnt_q <= ref_cnt_d;
			ref_div_q <= ref_div_d;
		end
	end

	// Prescaler and feedback divider
	logic variant_low_q, variant_low_d;
	logic [PRE_WIDTH-1:0] pre_cnt_q, pre_cnt_d, pre_base, pre_mod;
	logic [MAIN_WIDTH-1:0] main_left_q, main_left_d, main_load;
	logic [SWALLOW_WIDTH-1:0] swallow_left_q, swallow_left_d;
	logic pre_out, fb_div_q, fb_div_d;

	always_comb begin
		// modulus pair by variant and select
		if (variant_low_q) begin
			pre_base = func_latch_q.prescaler_high ? PRE_LOWF_HIGH : PRE_LOWF_LOW;
		end else begin
			pre_base = func_latch_q.prescaler_high ? PRE_STD_HIGH : PRE_STD_LOW;
		end
		pre_mod = pre_base + {{(PRE_WIDTH-1){1'b0}}, (swallow_left_q != '0)};
		main_load = (fb_latch_q.main_feedback_count < MAIN_MIN) ? MAIN_MIN : fb_latch_q.main_feedback_count;
		pre_cnt_d = pre_cnt_q;
		pre_out = 1'b0;
		if (pin_rise[PIN_RF]) begin
			if (pre_cnt_q >= pre_mod - 6'h01) begin
				pre_cnt_d = '0;
				pre_out = 1'b1;
			end else begin
				pre_cnt_d = pre_cnt_q + 6'h01;
			end
		end
		main_left_d = main_left_q;
		swallow_left_d = swallow_left_q;
		fb_div_d = 1'b0;
		// ratio P times main plus swallow
		if (pre_out) begin
			if (main_left_q <= MAIN_MIN) begin
				main_left_d = main_load;
				swallow_left_d = fb_latch_q.swallow_count;
				fb_div_d = 1'b1;
			end else begin
				main_left_d = main_left_q - 13'h0001;
				if (swallow_left_q != '0) begin
					swallow_left_d = swallow_left_q - 5'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt_q <= '0;
			main_left_q <= MAIN_RESET;
			swallow_left_q <= SWALLOW_RESET;
			fb_div_q <= 1'b0;
		end else begin
			pre_cnt_q <= pre_cnt_d;
			main_left_q <= main_left_d;
			swallow_left_q <= swallow_left_d;
			fb_div_q <= fb_div_d;
		end
	end

	// Phase/frequency detector
	logic up_q, up_d, down_q, down_d;
	logic pump_up_q, pump_up_d, pump_down_q, pump_down_d;

	always_comb begin
		// leading side pumps until the other arrives
		up_d = up_q | ref_div_q;
		down_d = down_q | fb_div_q;
		if (up_d && down_d) begin
			up_d = 1'b0;
			down_d = 1'b0;
		end
		pump_up_d = func_latch_q.pump_polarity ? up_d : down_d;
		pump_down_d = func_latch_q.pump_polarity ? down_d : up_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_q <= 1'b0;
			down_q <= 1'b0;
			pump_up_q <= 1'b0;
			pump_down_q <= 1'b0;
		end else begin
			up_q <= up_d;
			down_q <= down_d;
			pump_up_q <= pump_up_d;
			pump_down_q <= pump_down_d;
		end
	end

	assign pump_output_up = pump_up_q;
	assign pump_output_down = pump_down_q;
	assign ref_div_out = ref_div_q;
	assign fb_div_out = fb_div_q;

	// AXI4-Lite slave
	bus_state_type wr_state_q, wr_state_d, rd_state_q, rd_state_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [AXI_ADDR_WIDTH-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic wstrb0_q, wstrb0_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

	assign s_axi_awready = (wr_state_q == BUS_IDLE) && !aw_got_q;
	assign s_axi_wready = (wr_state_q == BUS_IDLE) && !w_got_q;
	assign s_axi_bvalid = (wr_state_q == BUS_RESP);
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = (rd_state_q == BUS_IDLE);
	assign s_axi_rvalid = (rd_state_q == BUS_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb begin
		wr_state_d = wr_state_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb0_d = wstrb0_q;
		bresp_d = bresp_q;
		variant_low_d = variant_low_q;
		case (wr_state_q)
			BUS_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_d = 1'b1;
					awaddr_d = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_d = 1'b1;
					wdata_d = s_axi_wdata;
					wstrb0_d = s_axi_wstrb[0];
				end
				if (aw_got_d && w_got_d) begin
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					wr_state_d = BUS_RESP;
					bresp_d = addr_mapped(awaddr_d) ? RESP_OKAY : RESP_SLVERR;
					if (awaddr_d == OFS_CTRL && wstrb0_d) begin
						variant_low_d = wdata_d[CTRL_VARIANT_BIT];
					end
				end
			end
			BUS_RESP: begin
				if (s_axi_bready) begin
					wr_state_d = BUS_IDLE;
				end
			end
			default: begin
				wr_state_d = BUS_IDLE;
			end
		endcase
	end

	always_comb begin
		rd_state_d = rd_state_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_state_q)
			BUS_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_d = BUS_RESP;
					rresp_d = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
					case (s_axi_araddr)
						OFS_CTRL: rdata_d = {31'h0, variant_low_q};
						OFS_STATUS: rdata_d = {28'h0, fb_div_q, ref_div_q, pump_down_q, pump_up_q};
						OFS_REF_LATCH: rdata_d = {17'h0, ref_latch_q.ratio};
						OFS_FB_LATCH: rdata_d = {14'h0, fb_latch_q};
						OFS_FUNC_LATCH: rdata_d = {30'h0, func_latch_q};
						OFS_SHIFT: rdata_d = {10'h0, shift_q};
						default: rdata_d = 32'h0;
					endcase
				end
			end
			BUS_RESP: begin
				if (s_axi_rready) begin
					rd_state_d = BUS_IDLE;
				end
			end
			default: begin
				rd_state_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= BUS_IDLE;
			rd_state_q <= BUS_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			variant_low_q <= CTRL_RESET;
		end else begin
			wr_state_q <= wr_state_d;
			rd_state_q <= rd_state_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb0_q <= wstrb0_d;
			bresp_q <= bresp_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			variant_low_q <= variant_low_d;
		end
	end
endmodule

// [hw/pll_pkg.sv]
// Shared constants and carrier types for the synthesizer divider chain.
// Assumes a single 25 MHz system clock and an AXI4-Lite register bus.
package pll_pkg;

	// Serial programming word
	localparam int SHIFT_WIDTH = 22;
	localparam int ADDR_LSB = 0;
	localparam logic [1:0] ADDR_REF = 2'h0;
	localparam logic [1:0] ADDR_FB = 2'h1;
	localparam logic [1:0] ADDR_FUNC = 2'h2;

	// Field positions inside the serial word
	localparam int REF_WIDTH = 15;
	localparam int REF_LSB = 2;
	localparam int SWALLOW_WIDTH = 5;
	localparam int SWALLOW_LSB = 2;
	localparam int MAIN_WIDTH = 13;
	localparam int MAIN_LSB = 7;
	localparam int PRESCALER_SEL_BIT = 2;
	localparam int POLARITY_BIT = 3;

	// Divider limits and latch reset values
	localparam logic [REF_WIDTH-1:0] REF_MIN = 15'h0002;
	localparam logic [REF_WIDTH-1:0] REF_RESET = 15'h000a;
	localparam logic [MAIN_WIDTH-1:0] MAIN_MIN = 13'h0001;
	localparam logic [MAIN_WIDTH-1:0] MAIN_RESET = 13'h0010;
	localparam logic [SWALLOW_WIDTH-1:0] SWALLOW_RESET = 5'h00;
	localparam logic PRESCALER_SEL_RESET = 1'b1;
	localparam logic POLARITY_RESET = 1'b1;

	// Prescaler lower moduli (upper modulus is one more)
	localparam int PRE_WIDTH = 6;
	localparam logic [PRE_WIDTH-1:0] PRE_STD_HIGH = 6'h20;
	localparam logic [PRE_WIDTH-1:0] PRE_STD_LOW = 6'h10;
	localparam logic [PRE_WIDTH-1:0] PRE_LOWF_HIGH = 6'h10;
	localparam logic [PRE_WIDTH-1:0] PRE_LOWF_LOW = 6'h08;

	// Pin indices into the synchroniser bank
	localparam int PIN_COUNT = 5;
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_LOAD = 2;
	localparam int PIN_REF = 3;
	localparam int PIN_RF = 4;

	// Register map (byte addresses)
	localparam int AXI_ADDR_WIDTH = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_REF_LATCH = 8'h08;
	localparam logic [7:0] OFS_FB_LATCH = 8'h0c;
	localparam logic [7:0] OFS_FUNC_LATCH = 8'h10;
	localparam logic [7:0] OFS_SHIFT = 8'h14;
	localparam int CTRL_VARIANT_BIT = 0;
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [REF_WIDTH-1:0] ratio;
	} ref_latch_type;

	typedef struct packed {
		logic [MAIN_WIDTH-1:0] main_feedback_count;
		logic [SWALLOW_WIDTH-1:0] swallow_count;
	} fb_latch_type;

	typedef struct packed {
		logic pump_polarity;
		logic prescaler_high;
	} func_latch_type;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_RESP = 1'b1
	} bus_state_type;

endpackage

// [tb/pll_chk.sv]
// Checker for the divider chain: bus handshakes, pump outputs, divider pulse spacing.
// Assumes bind into the top module; sees its ports only.
`timescale 1ns/1ns
module pll_chk
	import pll_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pump_output_up,
	input wire logic pump_output_down,
	input wire logic ref_div_out,
	input wire logic fb_div_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	write_resp_due_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid) else $error("write response late");
	write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	read_resp_due_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	read_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read response dropped");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");
	pump_exclusive_a: assert property (!(pump_output_up && pump_output_down))
		else $error("pump up and down together");
	pump_cause_a: assert property ($changed(pump_output_up) || $changed(pump_output_down)
		|-> $past(ref_div_out || fb_div_out) || $past(ref_div_out || fb_div_out, 2)
		|| (pump_output_up == $past(pump_output_down) && pump_output_down == $past(pump_output_up)))
		else $error("pump changed without divider pulse or polarity swap");
	ref_spacing_a: assert property (ref_div_out |=> !ref_div_out [*8])
		else $error("reference pulses too close");
	fb_spacing_a: assert property (fb_div_out |=> !fb_div_out [*8])
		else $error("feedback pulses too close");
endmodule

bind pll_divider_chain pll_chk u_pll_chk (.*);

// [tb/serial_host.sv]
// Host model driving the three-wire programming port.
// Assumes aclk from the bench; serial clock idles low between words.
`timescale 1ns/1ns
module serial_host (
	input wire logic aclk,
	output logic serial_clock,
	output logic serial_data,
	output logic load_strobe
);
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end

	task automatic send(input logic [21:0] w);
		for (int i = 21; i >= 0; i--) begin
			@(posedge aclk);
			serial_data <= w[i];
			repeat (4) @(posedge aclk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge aclk);
			serial_clock <= 1'b0;
		end
		repeat (4) @(posedge aclk);
		load_strobe <= 1'b1;
		serial_data <= ~w[0];
		repeat (4) @(posedge aclk);
		load_strobe <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
endmodule

// [tb/tb_top.sv]
// Bench: register reads and writes, serial programming, divider period checks.
// Assumes reference and RF pins toggle every 4 aclk cycles.
`timescale 1ns/1ns
module tb_top import pll_pkg::*;;
	logic aclk, aresetn;
	logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, pin_cnt;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic serial_clock, serial_data, load_strobe, ref_in, rf_in;
	logic pump_output_up, pump_output_down, ref_div_out, fb_div_out;
	// ref_in at aclk/8 keeps ratios below 15'h0100 under the limit; 15'h7fff is loaded but not timed
	logic [14:0] ratios [3] = '{15'h7fff, 15'h0002, 15'h0005};
	// rf_in is slow, so every modulus pair is allowed
	int fbv [3][4] = '{'{0, 1, 1, 0}, '{0, 0, 2, 1}, '{1, 0, 3, 2}};
	int mismatches, n_checks;

	pll_divider_chain u_pll_divider_chain (.*);
	serial_host u_serial_host (.*);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		pin_cnt <= pin_cnt + 3'h1;
		ref_in <= pin_cnt[2];
		rf_in <= pin_cnt[2];
	end

	task automatic results();
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(s, {30'h0, r}, {30'h0, RESP_OKAY});
		chk(s, d, e);
	endtask

	task automatic gap(input logic fb, output int n);
		n = 0;
		repeat (2) begin
			@(posedge aclk);
			while ((fb ? fb_div_out : ref_div_out) !== 1'b1) @(posedge aclk);
		end
		do begin
			@(posedge aclk);
			n++;
		end while ((fb ? fb_div_out : ref_div_out) !== 1'b1);
	endtask

	initial begin
		logic [31:0] d;
		logic [21:0] w;
		logic [1:0] r;
		int n;
		int p;
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready, aresetn, ref_in, rf_in, pin_cnt} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc("ctrl reset", OFS_CTRL, 32'(CTRL_RESET));
		rc("ref reset", OFS_REF_LATCH, 32'(REF_RESET));
		rc("fb reset", OFS_FB_LATCH, 32'({MAIN_RESET, SWALLOW_RESET}));
		rc("func reset", OFS_FUNC_LATCH, 32'({POLARITY_RESET, PRESCALER_SEL_RESET}));
		axr(8'h18, d, r);
		chk("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
		axw(8'h18, 32'h1, r);
		chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
		axw(OFS_STATUS, 32'hf, r);
		chk("status write", {30'h0, r}, {30'h0, RESP_OKAY});
		axw(OFS_CTRL, 32'h1, r);
		rc("ctrl write", OFS_CTRL, 32'h1);
		foreach (ratios[i]) begin
			w = (22'(ratios[i]) << REF_LSB) | 22'(ADDR_REF);
			u_serial_host.send(w);
			rc("shift word", OFS_SHIFT, 32'(w));
			rc("ref latch", OFS_REF_LATCH, 32'(ratios[i]));
			if (ratios[i] < 15'h0100) begin
				gap(1'b0, n);
				chk("ref period", 32'(n), 32'(ratios[i]) * 8);
			end
		end
		foreach (fbv[i]) begin
			p = fbv[i][0] ? (fbv[i][1] ? PRE_LOWF_HIGH : PRE_LOWF_LOW) : (fbv[i][1] ? PRE_STD_HIGH : PRE_STD_LOW);
			axw(OFS_CTRL, 32'(fbv[i][0]), r);
			w = 22'(ADDR_FUNC) | (22'(fbv[i][1]) << PRESCALER_SEL_BIT) | (22'h1 << POLARITY_BIT);
			u_serial_host.send(w);
			rc("func latch", OFS_FUNC_LATCH, 32'h2 | 32'(fbv[i][1]));
			w = 22'(ADDR_FB) | (22'(fbv[i][3]) << SWALLOW_LSB) | (22'(fbv[i][2]) << MAIN_LSB);
			u_serial_host.send(w);
			rc("fb latch", OFS_FB_LATCH, 32'(fbv[i][2] * 32 + fbv[i][3]));
			gap(1'b1, n);
			chk("fb period", 32'(n), 32'((p * fbv[i][2] + fbv[i][3]) * 8));
		end
		// Reference now leads feedback, so only its pump side shows after a lone reference pulse
		for (int pol = 1; pol >= 0; pol--) begin
			w = 22'(ADDR_FUNC) | (22'(pol) << POLARITY_BIT);
			u_serial_host.send(w);
			rc("func polarity", OFS_FUNC_LATCH, 32'(pol) << 1);
			repeat (3) begin
				@(posedge aclk);
				while (ref_div_out !== 1'b1 || fb_div_out !== 1'b0) @(posedge aclk);
				@(posedge aclk);
				chk("pump lead", {30'h0, pump_output_up, pump_output_down}, pol ? 32'h2 : 32'h1);
			end
		end
		results();
	end

	initial begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		results();
	end
endmodule
